//--- hdl/wwd_pkg.sv
package wwd_pkg;

    // ------------------------------------------------------------
    // timing, all in oscillator cycles
    // ------------------------------------------------------------
    localparam int unsigned POWER_UP_RESET_CYC   = 201;
    localparam int unsigned SWITCH_OVER_CYC      = 1112;
    localparam int unsigned RESET_OUT_CYC        = 40;
    localparam int unsigned SHORT_DISABLE_CYC    = 130;
    localparam int unsigned SHORT_ENABLE_CYC     = 124;
    localparam int unsigned LONG_DISABLE_CYC     = 71970;
    localparam int unsigned LONG_ENABLE_CYC      = 30002;
    localparam int unsigned TRIGGER_MAX_CYC      = 45;
    localparam int unsigned TRIGGER_DEBOUNCE_CYC = 4;
    localparam int unsigned WAKE_DEBOUNCE_CYC    = 128;

    // ------------------------------------------------------------
    // structure
    // ------------------------------------------------------------
    localparam int unsigned OSC_DIV_DEFAULT = 4;
    localparam int unsigned TIMER_W         = 17;
    localparam int unsigned GOOD_TRIGGERS   = 3;
    localparam int unsigned GOOD_CNT_W      = 2;
    localparam int unsigned CAUSE_W         = 3;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_POWER_UP,
        ST_SWITCH_OVER,
        ST_RESET_OUT,
        ST_SHORT_DISABLE,
        ST_SHORT_ENABLE,
        ST_LONG_DISABLE,
        ST_LONG_ENABLE
    } wwd_state_e;

    typedef enum logic [CAUSE_W-1:0] {
        CAUSE_NONE,
        CAUSE_SWITCH_TIMEOUT,
        CAUSE_EARLY_TRIGGER,
        CAUSE_MISSING_TRIGGER,
        CAUSE_OVERLONG_TRIGGER,
        CAUSE_WAKE_EDGE
    } wwd_cause_e;

endpackage

//--- hdl/wwd_debounce.sv
`timescale 1ns/1ns
module wwd_debounce #(
    parameter int unsigned STABLE_CYC = wwd_pkg::TRIGGER_DEBOUNCE_CYC,
    parameter logic        INIT_LEVEL = 1'b1
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic tick,
    input  wire logic pinRaw,
    output logic      levelDeb
);

    localparam int unsigned CW = $clog2(STABLE_CYC + 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic          sync0;
        logic          sync1;
        logic [CW-1:0] cnt;
        logic          level;
    } wwd_deb_s;

    wwd_deb_s s;
    wwd_deb_s next_s;

    // ------------------------------------------------------------
    // filter: a new level must hold for STABLE_CYC ticks
    // ------------------------------------------------------------
    always_comb begin
        next_s       = s;
        next_s.sync0 = pinRaw;
        next_s.sync1 = s.sync0;
        if (s.sync1 == s.level) begin
            next_s.cnt = '0;
        end else if (tick) begin
            if (s.cnt == CW'(STABLE_CYC - 1)) begin
                next_s.level = s.sync1;
                next_s.cnt   = '0;
            end else begin
                next_s.cnt = s.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '{sync0: INIT_LEVEL, sync1: INIT_LEVEL, cnt: '0, level: INIT_LEVEL};
        end else begin
            s <= next_s;
        end
    end

    assign levelDeb = s.level;

endmodule // wwd_debounce

//--- hdl/wwd_trigger_mon.sv
`timescale 1ns/1ns
module wwd_trigger_mon #(
    parameter int unsigned MAX_LOW_CYC = wwd_pkg::TRIGGER_MAX_CYC
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic tick,
    input  wire logic trgDeb,
    output logic      trgOk,
    output logic      trgErr
);

    localparam int unsigned CW = $clog2(MAX_LOW_CYC + 2);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic          prev;
        logic [CW-1:0] lowCnt;
        logic          ok;
        logic          err;
    } wwd_trg_s;

    wwd_trg_s s;
    wwd_trg_s next_s;

    always_comb begin
        next_s      = s;
        next_s.prev = trgDeb;
        next_s.ok   = trgDeb && !s.prev;
        if (trgDeb) begin
            next_s.lowCnt = '0;
            next_s.err    = 1'b0;
        end else if (tick && !s.err) begin
            // counter stops once the error is flagged, so it cannot wrap
            next_s.lowCnt = s.lowCnt + CW'(1);
            next_s.err    = (s.lowCnt == CW'(MAX_LOW_CYC));
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '{prev: 1'b1, lowCnt: '0, ok: 1'b0, err: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign trgOk  = s.ok;
    assign trgErr = s.err;

endmodule // wwd_trigger_mon

//--- hdl/wwd_watchdog.sv
`timescale 1ns/1ns
module wwd_watchdog #(
    parameter int unsigned OSC_DIV           = wwd_pkg::OSC_DIV_DEFAULT,
    parameter int unsigned SHORT_DISABLE_CYC = wwd_pkg::SHORT_DISABLE_CYC,
    parameter int unsigned SHORT_ENABLE_CYC  = wwd_pkg::SHORT_ENABLE_CYC,
    parameter int unsigned LONG_DISABLE_CYC  = wwd_pkg::LONG_DISABLE_CYC,
    parameter int unsigned LONG_ENABLE_CYC   = wwd_pkg::LONG_ENABLE_CYC,
    parameter int unsigned TRG_DEBOUNCE_CYC  = wwd_pkg::TRIGGER_DEBOUNCE_CYC,
    parameter int unsigned WAKE_DEBOUNCE_CYC = wwd_pkg::WAKE_DEBOUNCE_CYC,
    parameter int unsigned TRIGGER_MAX_CYC   = wwd_pkg::TRIGGER_MAX_CYC
) (
    input  wire logic                         clk,
    input  wire logic                         nrst,
    input  wire logic                         trgPin,
    input  wire logic                         modePin,
    input  wire logic                         wakeInput,
    output logic                              resetPinOut,
    output logic                              resetPinOe,
    output logic                              peripheralEnableOut,
    output logic                              longMode,
    output logic                              errorPulse,
    output logic [wwd_pkg::CAUSE_W-1:0]       errorCause
);

    localparam int unsigned TW  = wwd_pkg::TIMER_W;
    localparam int unsigned GW  = wwd_pkg::GOOD_CNT_W;
    localparam int unsigned DW  = $clog2(OSC_DIV + 1);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // a phase of n ticks loads n-1 and ends on the tick that sees zero
    function automatic logic [TW-1:0] phaseLoad(input int unsigned cyc);
        phaseLoad = TW'(cyc - 1);
    endfunction

    localparam logic [TW-1:0] POWER_UP_LOAD = TW'(wwd_pkg::POWER_UP_RESET_CYC - 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DW-1:0]       divCnt;
        logic                tick;
        wwd_pkg::wwd_state_e state;
        logic [TW-1:0]       timer;
        logic [GW-1:0]       goodCnt;
        logic                ena;
        logic                rstActive;
        logic                rstLevel;
        logic                wakePrev;
        logic                errPulse;
        wwd_pkg::wwd_cause_e cause;
    } wwd_core_s;

    wwd_core_s s;
    wwd_core_s next_s;

    logic modeDeb;
    logic trgDeb;
    logic wakeDeb;
    logic trgOk;
    logic trgErr;
    logic timerDone;
    logic wakeEdge;

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    // pull-ups on trigger and mode, pull-down on wake: idle levels
    wwd_debounce #(
        .STABLE_CYC (TRG_DEBOUNCE_CYC),
        .INIT_LEVEL (1'b1)
    ) uTrgDeb (
        .clk      (clk),
        .nrst     (nrst),
        .tick     (s.tick),
        .pinRaw   (trgPin),
        .levelDeb (trgDeb)
    );

    wwd_debounce #(
        .STABLE_CYC (TRG_DEBOUNCE_CYC),
        .INIT_LEVEL (1'b1)
    ) uModeDeb (
        .clk      (clk),
        .nrst     (nrst),
        .tick     (s.tick),
        .pinRaw   (modePin),
        .levelDeb (modeDeb)
    );

    wwd_debounce #(
        .STABLE_CYC (WAKE_DEBOUNCE_CYC),
        .INIT_LEVEL (1'b0)
    ) uWakeDeb (
        .clk      (clk),
        .nrst     (nrst),
        .tick     (s.tick),
        .pinRaw   (wakeInput),
        .levelDeb (wakeDeb)
    );

    wwd_trigger_mon #(
        .MAX_LOW_CYC (TRIGGER_MAX_CYC)
    ) uTrgMon (
        .clk    (clk),
        .nrst   (nrst),
        .tick   (s.tick),
        .trgDeb (trgDeb),
        .trgOk  (trgOk),
        .trgErr (trgErr)
    );

    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    assign timerDone = s.tick && (s.timer == '0);
    assign wakeEdge  = (wakeDeb != s.wakePrev);

    // ------------------------------------------------------------
    // reset pulse entry, shared by every fault
    // ------------------------------------------------------------
    function automatic wwd_core_s enterReset(input wwd_core_s st, input wwd_pkg::wwd_cause_e why);
        wwd_core_s r;
        r           = st;
        r.state     = wwd_pkg::ST_RESET_OUT;
        r.timer     = phaseLoad(wwd_pkg::RESET_OUT_CYC);
        r.rstActive = 1'b1;
        r.ena       = 1'b0;
        r.goodCnt   = '0;
        r.errPulse  = 1'b1;
        r.cause     = why;
        return r;
    endfunction

    // ------------------------------------------------------------
    // main state machine
    // ------------------------------------------------------------
    always_comb begin
        next_s          = s;
        next_s.errPulse = 1'b0;
        next_s.wakePrev = wakeDeb;

        // slow-rate enable: one clk pulse per oscillator cycle
        if (s.divCnt == DW'(OSC_DIV - 1)) begin
            next_s.divCnt = '0;
            next_s.tick   = 1'b1;
        end else begin
            next_s.divCnt = s.divCnt + DW'(1);
            next_s.tick   = 1'b0;
        end

        if (s.tick && (s.timer != '0)) begin
            next_s.timer = s.timer - TW'(1);
        end

        case (s.state)
            wwd_pkg::ST_POWER_UP: begin
                if (timerDone) begin
                    next_s.state     = wwd_pkg::ST_SWITCH_OVER;
                    next_s.timer     = phaseLoad(wwd_pkg::SWITCH_OVER_CYC);
                    next_s.rstActive = 1'b0;
                end
            end
            wwd_pkg::ST_SWITCH_OVER: begin
                if (!modeDeb) begin
                    next_s.state = wwd_pkg::ST_SHORT_DISABLE;
                    next_s.timer = phaseLoad(SHORT_DISABLE_CYC);
                end else if (timerDone) begin
                    next_s = enterReset(next_s, wwd_pkg::CAUSE_SWITCH_TIMEOUT);
                end
            end
            wwd_pkg::ST_RESET_OUT: begin
                if (timerDone) begin
                    // resync: every pulse is followed by a fresh switch-over
                    next_s.state     = wwd_pkg::ST_SWITCH_OVER;
                    next_s.timer     = phaseLoad(wwd_pkg::SWITCH_OVER_CYC);
                    next_s.rstActive = 1'b0;
                end
            end
            wwd_pkg::ST_SHORT_DISABLE: begin
                if (trgErr) begin
                    next_s = enterReset(next_s, wwd_pkg::CAUSE_OVERLONG_TRIGGER);
                end else if (trgOk) begin
                    next_s = enterReset(next_s, wwd_pkg::CAUSE_EARLY_TRIGGER);
                end else if (modeDeb) begin
                    next_s.state   = wwd_pkg::ST_LONG_DISABLE;
                    next_s.timer   = phaseLoad(LONG_DISABLE_CYC);
                    next_s.ena     = 1'b0;
                    next_s.goodCnt = '0;
                end else if (timerDone) begin
                    next_s.state = wwd_pkg::ST_SHORT_ENABLE;
                    next_s.timer = phaseLoad(SHORT_ENABLE_CYC);
                end
            end
            wwd_pkg::ST_SHORT_ENABLE: begin
                if (trgErr) begin
                    next_s = enterReset(next_s, wwd_pkg::CAUSE_OVERLONG_TRIGGER);
                end else if (trgOk) begin
                    next_s.state = wwd_pkg::ST_SHORT_DISABLE;
                    next_s.timer = phaseLoad(SHORT_DISABLE_CYC);
                    if (s.goodCnt == GW'(wwd_pkg::GOOD_TRIGGERS - 1)) begin
                        next_s.ena = 1'b1;
                    end else begin
                        next_s.goodCnt = s.goodCnt + GW'(1);
                    end
                end else if (modeDeb) begin
                    next_s.state   = wwd_pkg::ST_LONG_DISABLE;
                    next_s.timer   = phaseLoad(LONG_DISABLE_CYC);
                    next_s.ena     = 1'b0;
                    next_s.goodCnt = '0;
                end else if (timerDone) begin
                    next_s = enterReset(next_s, wwd_pkg::CAUSE_MISSING_TRIGGER);
                end
            end
            wwd_pkg::ST_LONG_DISABLE: begin
                if (wakeEdge) begin
                    next_s = enterReset(next_s, wwd_pkg::CAUSE_WAKE_EDGE);
                end else if (trgErr) begin
                    next_s = enterReset(next_s, wwd_pkg::CAUSE_OVERLONG_TRIGGER);
                end else if (trgOk) begin
                    next_s = enterReset(next_s, wwd_pkg::CAUSE_EARLY_TRIGGER);
                end else if (!modeDeb) begin
                    next_s.state = wwd_pkg::ST_SHORT_DISABLE;
                    next_s.timer = phaseLoad(SHORT_DISABLE_CYC);
                end else if (timerDone) begin
                    next_s.state = wwd_pkg::ST_LONG_ENABLE;
                    next_s.timer = phaseLoad(LONG_ENABLE_CYC);
                end
            end
            wwd_pkg::ST_LONG_ENABLE: begin
                if (wakeEdge) begin
                    next_s = enterReset(next_s, wwd_pkg::CAUSE_WAKE_EDGE);
                end else if (trgErr) begin
                    next_s = enterReset(next_s, wwd_pkg::CAUSE_OVERLONG_TRIGGER);
                end else if (trgOk) begin
                    next_s.state = wwd_pkg::ST_LONG_DISABLE;
                    next_s.timer = phaseLoad(LONG_DISABLE_CYC);
                end else if (!modeDeb) begin
                    next_s.state = wwd_pkg::ST_SHORT_DISABLE;
                    next_s.timer = phaseLoad(SHORT_DISABLE_CYC);
                end else if (timerDone) begin
                    next_s = enterReset(next_s, wwd_pkg::CAUSE_MISSING_TRIGGER);
                end
            end
            default: begin
                next_s = enterReset(next_s, wwd_pkg::CAUSE_NONE);
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // reset pin is open drain: only the enable moves, level stays low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s.divCnt    <= '0;
            s.tick      <= 1'b0;
            s.state     <= wwd_pkg::ST_POWER_UP;
            s.timer     <= POWER_UP_LOAD;
            s.goodCnt   <= '0;
            s.ena       <= 1'b0;
            s.rstActive <= 1'b1;
            s.rstLevel  <= 1'b0;
            s.wakePrev  <= 1'b0;
            s.errPulse  <= 1'b0;
            s.cause     <= wwd_pkg::CAUSE_NONE;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign resetPinOut         = s.rstLevel;
    assign resetPinOe          = s.rstActive;
    assign peripheralEnableOut = s.ena;
    assign longMode            = (s.state == wwd_pkg::ST_LONG_DISABLE) || (s.state == wwd_pkg::ST_LONG_ENABLE);
    assign errorPulse          = s.errPulse;
    assign errorCause          = s.cause;

endmodule // wwd_watchdog

//--- test/wwd_mcu_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// supervised controller: trigger, mode and wake lines
// ------------------------------------------------------------
module wwd_mcu_model (
    input  wire logic       clk,
    input  wire logic       modeLvl,
    input  wire logic       wakeLvl,
    input  wire logic       pulseGo,
    input  wire logic [7:0] pulseLen,
    output logic            trgPin,
    output logic            modePin,
    output logic            wakeInput
);
    logic [7:0] lowCnt = 8'h00;

    // low phase length is chosen per request; bench keeps it legal except on purpose
    always_ff @(posedge clk) begin
        if (pulseGo) begin
            lowCnt <= pulseLen;
        end else if (lowCnt != 8'h00) begin
            lowCnt <= lowCnt - 8'h01;
        end
    end

    // released trigger line falls back to its pull-up level
    assign trgPin    = (lowCnt == 8'h00);
    assign modePin   = modeLvl;
    assign wakeInput = wakeLvl;
endmodule // wwd_mcu_model

//--- test/wwd_watchdog_props.sv
`timescale 1ns/1ns
module wwd_watchdog_props #(
    parameter int unsigned OSC_DIV           = wwd_pkg::OSC_DIV_DEFAULT,
    parameter int unsigned SHORT_DISABLE_CYC = wwd_pkg::SHORT_DISABLE_CYC,
    parameter int unsigned SHORT_ENABLE_CYC  = wwd_pkg::SHORT_ENABLE_CYC
) (
    input wire logic                         clk,
    input wire logic                         nrst,
    input wire logic                         resetPinOe,
    input wire logic                         peripheralEnableOut,
    input wire logic                         longMode,
    input wire logic                         errorPulse,
    input wire logic [wwd_pkg::CAUSE_W-1:0]  errorCause
);
    // tick phase adds a few clocks of slack to every length except EN_LO
    localparam int PU_LO = 201 * OSC_DIV - 2;
    localparam int PU_HI = 201 * OSC_DIV + OSC_DIV + 3;
    localparam int RO_LO = 40 * OSC_DIV - 2;
    localparam int RO_HI = 40 * OSC_DIV + OSC_DIV + 3;
    localparam int SW_LO = 1112 * OSC_DIV - 4;
    localparam int SW_HI = 1112 * OSC_DIV + OSC_DIV + 4;
    localparam int MS_LO = (SHORT_DISABLE_CYC + SHORT_ENABLE_CYC) * OSC_DIV - 2;
    localparam int EN_LO = 3 * SHORT_DISABLE_CYC * OSC_DIV;

    logic [16:0] hiCnt;
    logic [16:0] loCnt;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hiCnt <= 17'h00000;
            loCnt <= 17'h00000;
        end else begin
            hiCnt <= resetPinOe ? hiCnt + 17'h00001 : 17'h00000;
            loCnt <= resetPinOe ? 17'h00000 : ((loCnt == 17'h1FFFF) ? loCnt : loCnt + 17'h00001);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_hold;
        (!errorPulse && resetPinOe) [*8];
    endsequence
    sequence s_fault;
        errorPulse && resetPinOe && !peripheralEnableOut;
    endsequence

    property p_reset_state;
        $rose(nrst) |-> resetPinOe && !peripheralEnableOut && !longMode && errorCause == 3'h0;
    endproperty
    property p_oe_len;
        $fell(resetPinOe) |-> (hiCnt >= RO_LO && hiCnt <= RO_HI) || (hiCnt >= PU_LO && hiCnt <= PU_HI);
    endproperty
    property p_err_pulse;
        errorPulse |-> s_fault ##1 s_hold;
    endproperty
    property p_switch_len;
        errorPulse && errorCause == wwd_pkg::CAUSE_SWITCH_TIMEOUT |-> loCnt >= SW_LO && loCnt <= SW_HI;
    endproperty
    property p_long_off;
        longMode |-> !peripheralEnableOut;
    endproperty
    property p_enable_late;
        $rose(peripheralEnableOut) |-> !longMode && loCnt > EN_LO;
    endproperty
    property p_missing;
        errorPulse && errorCause == wwd_pkg::CAUSE_MISSING_TRIGGER |-> loCnt >= MS_LO;
    endproperty
    property p_wake;
        errorPulse && errorCause == wwd_pkg::CAUSE_WAKE_EDGE |-> $past(longMode);
    endproperty
    property p_overlong;
        errorPulse && errorCause == wwd_pkg::CAUSE_OVERLONG_TRIGGER |-> loCnt > 46 * OSC_DIV;
    endproperty

    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
    a_oe_len: assert property (p_oe_len) else $error("reset output length wrong");
    a_err_pulse: assert property (p_err_pulse) else $error("fault pulse shape wrong");
    a_switch_len: assert property (p_switch_len) else $error("switch-over length wrong");
    a_long_off: assert property (p_long_off) else $error("enable in long mode");
    a_enable_late: assert property (p_enable_late) else $error("enable too early");
    a_missing: assert property (p_missing) else $error("missing fault too early");
    a_wake: assert property (p_wake) else $error("wake fault outside long mode");
    a_overlong: assert property (p_overlong) else $error("overlong fault too early");
endmodule // wwd_watchdog_props

bind wwd_watchdog wwd_watchdog_props #(
    .OSC_DIV(OSC_DIV),
    .SHORT_DISABLE_CYC(SHORT_DISABLE_CYC),
    .SHORT_ENABLE_CYC(SHORT_ENABLE_CYC)
) wwd_watchdog_props_inst (
    .clk(clk),
    .nrst(nrst),
    .resetPinOe(resetPinOe),
    .peripheralEnableOut(peripheralEnableOut),
    .longMode(longMode),
    .errorPulse(errorPulse),
    .errorCause(errorCause)
);

//--- test/testbench.sv
`timescale 1ns/1ns
module testbench;
    // short windows keep the run brief; fixed lengths stay as built
    localparam int unsigned SD = 40;
    localparam int unsigned SE = 50;
    localparam int unsigned LD = 80;
    localparam int unsigned LE = 40;

    logic                        clk = 1'b0;
    logic                        nrst = 1'b0;
    logic                        modeLvl = 1'b1;
    logic                        wakeLvl = 1'b0;
    logic                        pulseGo = 1'b0;
    logic [7:0]                  pulseLen = 8'h00;
    logic                        trgPin;
    logic                        modePin;
    logic                        wakeInput;
    logic                        resetPinOut;
    logic                        resetPinOe;
    logic                        peripheralEnableOut;
    logic                        longMode;
    logic                        errorPulse;
    logic [wwd_pkg::CAUSE_W-1:0] errorCause;
    int                          err_count = 0;
    int                          comparisons = 0;
    int                          n;

    always #5 clk = ~clk;

    wwd_mcu_model wwd_mcu_model_inst (.clk(clk), .modeLvl(modeLvl), .wakeLvl(wakeLvl), .pulseGo(pulseGo),
        .pulseLen(pulseLen), .trgPin(trgPin), .modePin(modePin), .wakeInput(wakeInput));

    wwd_watchdog #(.OSC_DIV(1), .SHORT_DISABLE_CYC(SD), .SHORT_ENABLE_CYC(SE), .LONG_DISABLE_CYC(LD),
        .LONG_ENABLE_CYC(LE), .WAKE_DEBOUNCE_CYC(8)) wwd_watchdog_inst (.clk(clk), .nrst(nrst),
        .trgPin(trgPin), .modePin(modePin), .wakeInput(wakeInput), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
        .peripheralEnableOut(peripheralEnableOut), .longMode(longMode), .errorPulse(errorPulse),
        .errorCause(errorCause));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic range_chk(input int v, input int lo, input int hi, input string what);
        check((v >= lo && v <= hi) ? 16'h0001 : 16'h0000, 16'h0001, what);
    endtask

    // sampled at falling edges, where outputs have settled
    task automatic wait_for(input bit onErr, input logic lvl, input int bound, output int cnt);
        cnt = 0;
        while ((onErr ? errorPulse : resetPinOe) !== lvl) begin
            @(negedge clk);
            cnt++;
            if (cnt > bound) begin
                err_count++;
                $display("Error at %0t: wait expired", $time);
                end_of_test();
            end
        end
    endtask

    task automatic idle(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic trig(input logic [7:0] len);
        @(negedge clk);
        pulseGo = 1'b1;
        pulseLen = len;
        @(negedge clk);
        pulseGo = 1'b0;
    endtask

    // each rise lands well inside the enable time of the previous cycle
    task automatic trigs(input int k);
        repeat (k) begin
            idle(53);
            trig(8'h0A);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_power_up;
        idle(12);
        check(16'(resetPinOe), 16'h0001, "oe in reset");
        check(16'(resetPinOut), 16'h0000, "rst lvl");
        check(16'(peripheralEnableOut), 16'h0000, "enable in reset");
        nrst = 1'b1;
        wait_for(1'b0, 1'b0, 400, n);
        range_chk(n, 199, 206, "power-up length");
        $display("test power_up done");
    endtask

    task automatic t_switch;
        wait_for(1'b0, 1'b1, 1300, n);
        range_chk(n, 1108, 1118, "switch-over length");
        check(16'(errorCause), 16'h0001, "switch cause");
        wait_for(1'b0, 1'b0, 100, n);
        range_chk(n, 38, 44, "reset pulse length");
        $display("test switch done");
    endtask

    task automatic t_good;
        modeLvl = 1'b0;
        trigs(2);
        check(16'(peripheralEnableOut), 16'h0000, "enable after two");
        trigs(1);
        idle(20);
        check(16'(peripheralEnableOut), 16'h0001, "enable after three");
        check(16'(resetPinOe), 16'h0000, "no reset on good");
        $display("test good done");
    endtask

    task automatic t_early;
        idle(14);
        trig(8'h0A);
        wait_for(1'b1, 1'b1, 60, n);
        check(16'(errorCause), 16'h0002, "early cause");
        check(16'(peripheralEnableOut), 16'h0000, "enable cleared");
        wait_for(1'b0, 1'b0, 100, n);
        trigs(2);
        check(16'(peripheralEnableOut), 16'h0000, "enable after two again");
        trigs(1);
        idle(20);
        check(16'(peripheralEnableOut), 16'h0001, "enable after three again");
        $display("test early done");
    endtask

    task automatic t_missing;
        idle(40);
        trig(8'h02);
        wait_for(1'b1, 1'b1, 200, n);
        check(16'(errorCause), 16'h0003, "missing cause");
        check(16'(peripheralEnableOut), 16'h0000, "enable after missing");
        $display("test missing done");
    endtask

    task automatic t_overlong;
        wait_for(1'b0, 1'b0, 100, n);
        idle(4);
        trig(8'd60);
        wait_for(1'b1, 1'b1, 120, n);
        check(16'(errorCause), 16'h0004, "overlong cause");
        $display("test overlong done");
    endtask

    task automatic t_long;
        wait_for(1'b0, 1'b0, 100, n);
        idle(10);
        modeLvl = 1'b1;
        idle(15);
        check(16'(longMode), 16'h0001, "long entered");
        check(16'(peripheralEnableOut), 16'h0000, "enable in long");
        modeLvl = 1'b0;
        idle(15);
        check(16'(longMode), 16'h0000, "back to short");
        modeLvl = 1'b1;
        idle(15);
        wakeLvl = 1'b1;
        idle(4);
        wakeLvl = 1'b0;
        idle(16);
        check(16'(resetPinOe), 16'h0000, "short wake ignored");
        check(16'(longMode), 16'h0001, "still long");
        wakeLvl = 1'b1;
        wait_for(1'b1, 1'b1, 40, n);
        check(16'(errorCause), 16'h0005, "wake cause");
        range_chk(n, 9, 16, "wake debounce delay");
        $display("test long done");
    endtask

    task automatic t_long_timeout;
        wait_for(1'b0, 1'b0, 100, n);
        modeLvl = 1'b0;
        idle(20);
        modeLvl = 1'b1;
        wait_for(1'b1, 1'b1, 250, n);
        range_chk(n, LD + LE + 2, LD + LE + 14, "long window length");
        check(16'(errorCause), 16'h0003, "long missing cause");
        $display("test long_timeout done");
    endtask

    initial begin
        t_power_up();
        t_switch();
        t_good();
        t_early();
        t_missing();
        t_overlong();
        t_long();
        t_long_timeout();
        end_of_test();
    end
endmodule // testbench
